/* hdl/bst_pkg.sv */
// Constants, codes and state encoding for the boundary-scan test port
// Functional notes
// - Test reset release leaves controller in Test-Logic-Reset with identification instruction.
// - Five rising test clocks with mode select high reach Test-Logic-Reset.
// - Controller advances only on rising test clock, steered by mode select.
// - Select-DR goes Capture-DR on low, Select-IR on high; registers hold.
// - Capture-DR loads selected register if allowed; then Shift-DR low, Exit1-DR high.
// - Shift-DR shifts selected register one stage per rising edge; others hold.
// - Exit1-DR goes Update-DR on high, Pause-DR on low.
// - Pause-DR holds registers; stays on low, Exit2-DR on high.
// - Exit2-DR goes Update-DR on high, back to Shift-DR on low.
// - Update-DR falling edge latches shift path; then Idle low, Select-DR high.
// - Select-IR goes Capture-IR on low, Test-Logic-Reset on high.
// - Capture-IR loads 001 into instruction shifter; Exit1-IR high, Shift-IR low.
// - Shift-IR shifts instruction one stage per edge; Exit1-IR on high.
// - Exit1-IR, Pause-IR, Exit2-IR follow the standard instruction branch.
// - Falling edge in Update-IR makes shifted instruction current.
// - Sample/preload captures inputs in Capture-DR without disturbing operation.
// - Extest drives outputs from boundary latches updated on Update-DR falling edge.
// - Bypass puts one-bit register between serial in and out.
// - Idcode loads identification code in Capture-DR, shifts it out.
// - Highz floats all outputs and selects bypass.
// - Clamp holds outputs from boundary latches with bypass selected.
package bst_pkg;
   localparam int IR_W = 3;
   localparam logic [2:0] IR_EXTEST  = 3'h0;
   localparam logic [2:0] IR_IDCODE  = 3'h1;
   localparam logic [2:0] IR_SAMPLE  = 3'h2;
   localparam logic [2:0] IR_CLAMP   = 3'h3;
   localparam logic [2:0] IR_HIGHZ   = 3'h4;
   localparam logic [2:0] IR_BYPASS  = 3'h7;
   localparam logic [2:0] IR_CAPTURE = 3'h1;
   localparam int TLR_CLKS = 5;
   localparam int SYNC_STAGES = 2;
   // Identification fields, values arbitrary
   localparam logic [3:0]  ID_VERSION = 4'hA;
   localparam logic [15:0] ID_PART    = 16'h5C3E;
   localparam logic [10:0] ID_MAKER   = 11'h2B5;

   typedef enum logic [15:0] {
      ST_TLR    = 16'h0001,
      ST_IDLE   = 16'h0002,
      ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008,
      ST_SH_DR  = 16'h0010,
      ST_EX1_DR = 16'h0020,
      ST_PAU_DR = 16'h0040,
      ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100,
      ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400,
      ST_SH_IR  = 16'h0800,
      ST_EX1_IR = 16'h1000,
      ST_PAU_IR = 16'h2000,
      ST_EX2_IR = 16'h4000,
      ST_UPD_IR = 16'h8000
   } bst_state_t;

   function automatic logic sel_bsr(input logic [2:0] ir);
      sel_bsr = (ir == IR_EXTEST) || (ir == IR_SAMPLE);
   endfunction

   function automatic logic drive_bsr(input logic [2:0] ir);
      drive_bsr = (ir == IR_EXTEST) || (ir == IR_CLAMP);
   endfunction
endpackage

/* hdl/bst_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module bst_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   if (W < 1) begin : g_chk
      $error("bst_sync needs at least one bit");
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         q_o    <= '0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule

/* hdl/bst_ctrl.sv */
// Sixteen-state test port controller
`timescale 1ns/100ps
module bst_ctrl (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          trst_n_i,
   input  wire logic          tck_rise_i,
   input  wire logic          tms_i,
   output bst_pkg::bst_state_t state_o
);
   bst_pkg::bst_state_t nxt;

   always_comb begin
      case (state_o)
         bst_pkg::ST_TLR:    nxt = tms_i ? bst_pkg::ST_TLR    : bst_pkg::ST_IDLE;
         bst_pkg::ST_IDLE:   nxt = tms_i ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_DR: nxt = tms_i ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
         bst_pkg::ST_CAP_DR: nxt = tms_i ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_SH_DR:  nxt = tms_i ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_EX1_DR: nxt = tms_i ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
         bst_pkg::ST_PAU_DR: nxt = tms_i ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
         bst_pkg::ST_EX2_DR: nxt = tms_i ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
         bst_pkg::ST_UPD_DR: nxt = tms_i ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         bst_pkg::ST_SEL_IR: nxt = tms_i ? bst_pkg::ST_TLR    : bst_pkg::ST_CAP_IR;
         bst_pkg::ST_CAP_IR: nxt = tms_i ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_SH_IR:  nxt = tms_i ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_EX1_IR: nxt = tms_i ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
         bst_pkg::ST_PAU_IR: nxt = tms_i ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
         bst_pkg::ST_EX2_IR: nxt = tms_i ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
         bst_pkg::ST_UPD_IR: nxt = tms_i ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
         default:            nxt = bst_pkg::ST_TLR;
      endcase
   end

   // Test reset acts as a synchronous force once synchronised
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_o <= bst_pkg::ST_TLR;
      end else if (!trst_n_i) begin
         state_o <= bst_pkg::ST_TLR;
      end else if (tck_rise_i) begin
         state_o <= nxt;
      end
   end
endmodule

/* hdl/bst_tap.sv */
// Boundary-scan test access port with instruction and data registers
`timescale 1ns/100ps
module bst_tap #(
   parameter int N_IN  = 8,
   parameter int N_OUT = 8
) (
   input  wire logic             MCLK_I,
   input  wire logic             RESET_I,
   input  wire logic             TEST_CLOCK_IN_I,
   input  wire logic             TEST_MODE_SELECT_I,
   input  wire logic             TEST_SERIAL_IN_I,
   input  wire logic             TEST_RESET_N_I,
   input  wire logic [N_IN-1:0]  PIN_IN_I,
   input  wire logic [N_OUT-1:0] CORE_OUT_I,
   input  wire logic [N_OUT-1:0] CORE_OE_N_I,
   output logic      [N_IN-1:0]  CORE_IN_O,
   output logic      [N_OUT-1:0] PIN_O,
   output logic      [N_OUT-1:0] PIN_OE_N_O,
   output logic                  TEST_SERIAL_OUT_O,
   output logic                  TEST_SERIAL_OUT_OE_N_O
);
   localparam int BSR_LEN = N_IN + N_OUT;
   localparam int ID_W    = 32;
   localparam logic [ID_W-1:0] ID_CODE =
      {bst_pkg::ID_VERSION, bst_pkg::ID_PART, bst_pkg::ID_MAKER, 1'b1};

   if (N_IN < 1 || N_OUT < 1) begin : g_chk
      $error("bst_tap needs at least one input and one output cell");
   end

   // Pin synchronisation
   logic [N_IN+3:0] sync_s;
   logic            tck_s;
   logic            tms_s;
   logic            tdi_s;
   logic            trst_n_s;
   logic [N_IN-1:0] pin_in_s;

   bst_sync #(
      .W (N_IN + 4)
   ) u_sync (
      .clk_i (MCLK_I),
      .rst_i (RESET_I),
      .d_i   ({PIN_IN_I, TEST_RESET_N_I, TEST_SERIAL_IN_I,
               TEST_MODE_SELECT_I, TEST_CLOCK_IN_I}),
      .q_o   (sync_s)
   );

   assign tck_s    = sync_s[0];
   assign tms_s    = sync_s[1];
   assign tdi_s    = sync_s[2];
   assign trst_n_s = sync_s[3];
   assign pin_in_s = sync_s[N_IN+3:4];

   // Test clock edges seen on the system clock
   logic tck_d_q;
   logic tck_rise;
   logic tck_fall;

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         tck_d_q <= 1'b0;
      end else begin
         tck_d_q <= tck_s;
      end
   end

   assign tck_rise = tck_s & ~tck_d_q;
   assign tck_fall = ~tck_s & tck_d_q;

   // Controller
   bst_pkg::bst_state_t state;

   bst_ctrl u_ctrl (
      .clk_i      (MCLK_I),
      .rst_i      (RESET_I),
      .trst_n_i   (trst_n_s),
      .tck_rise_i (tck_rise),
      .tms_i      (tms_s),
      .state_o    (state)
   );

   // State decodes
   wire st_tlr    = (state == bst_pkg::ST_TLR);
   wire st_cap_dr = (state == bst_pkg::ST_CAP_DR);
   wire st_sh_dr  = (state == bst_pkg::ST_SH_DR);
   wire st_upd_dr = (state == bst_pkg::ST_UPD_DR);
   wire st_cap_ir = (state == bst_pkg::ST_CAP_IR);
   wire st_sh_ir  = (state == bst_pkg::ST_SH_IR);
   wire st_upd_ir = (state == bst_pkg::ST_UPD_IR);
   wire st_idle     = (state == bst_pkg::ST_IDLE);
   wire st_sel_dr_w = (state == bst_pkg::ST_SEL_DR);
   wire st_pau_dr_w = (state == bst_pkg::ST_PAU_DR);
   wire st_sel_ir   = (state == bst_pkg::ST_SEL_IR);

   // Instruction register
   logic [bst_pkg::IR_W-1:0] ir_sr_q;
   logic [bst_pkg::IR_W-1:0] ir_q;

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         ir_sr_q <= bst_pkg::IR_CAPTURE;
      end else if (tck_rise && st_cap_ir) begin
         ir_sr_q <= bst_pkg::IR_CAPTURE;
      end else if (tck_rise && st_sh_ir) begin
         ir_sr_q <= {tdi_s, ir_sr_q[bst_pkg::IR_W-1:1]};
      end
   end

   // Reset forces the identification instruction; update happens on a falling edge
   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         ir_q <= bst_pkg::IR_IDCODE;
      end else if (!trst_n_s || st_tlr) begin
         ir_q <= bst_pkg::IR_IDCODE;
      end else if (tck_fall && st_upd_ir) begin
         ir_q <= ir_sr_q;
      end
   end

   // Data register selection, unassigned codes fall to bypass
   wire sel_bsr = bst_pkg::sel_bsr(ir_q);
   wire sel_id  = (ir_q == bst_pkg::IR_IDCODE);
   wire sel_byp = !sel_bsr && !sel_id;

   // Boundary, identification and bypass registers
   logic [BSR_LEN-1:0] bsr_sr_q;
   logic [BSR_LEN-1:0] bsr_upd_q;
   logic [ID_W-1:0]    id_sr_q;
   logic               byp_q;

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         bsr_sr_q <= '0;
      end else if (tck_rise && st_cap_dr && sel_bsr) begin
         bsr_sr_q <= {CORE_OUT_I, pin_in_s};
      end else if (tck_rise && st_sh_dr && sel_bsr) begin
         bsr_sr_q <= {tdi_s, bsr_sr_q[BSR_LEN-1:1]};
      end
   end

   // Update latch shields the pins from shifting activity
   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         bsr_upd_q <= '0;
      end else if (tck_fall && st_upd_dr && sel_bsr) begin
         bsr_upd_q <= bsr_sr_q;
      end
   end

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         id_sr_q <= '0;
      end else if (tck_rise && st_cap_dr && sel_id) begin
         id_sr_q <= ID_CODE;
      end else if (tck_rise && st_sh_dr && sel_id) begin
         id_sr_q <= {tdi_s, id_sr_q[ID_W-1:1]};
      end
   end

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         byp_q <= 1'b0;
      end else if (tck_rise && st_cap_dr && sel_byp) begin
         byp_q <= 1'b0;
      end else if (tck_rise && st_sh_dr && sel_byp) begin
         byp_q <= tdi_s;
      end
   end

   // Serial out mux
   wire dr_bit  = sel_bsr ? bsr_sr_q[0] : (sel_id ? id_sr_q[0] : byp_q);
   wire tdo_bit = st_sh_ir ? ir_sr_q[0] : dr_bit;

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         TEST_SERIAL_OUT_O      <= 1'b0;
         TEST_SERIAL_OUT_OE_N_O <= 1'b1;
      end else if (tck_fall) begin
         TEST_SERIAL_OUT_O      <= tdo_bit;
         TEST_SERIAL_OUT_OE_N_O <= !(st_sh_dr || st_sh_ir);
      end
   end

   // Pin drive selection, follows the current instruction
   wire             mode_hiz = (ir_q == bst_pkg::IR_HIGHZ);
   wire             mode_bsr = bst_pkg::drive_bsr(ir_q);
   wire [N_OUT-1:0] upd_out  = bsr_upd_q[BSR_LEN-1:N_IN];
   wire [N_OUT-1:0] pin_d    = mode_bsr ? upd_out : CORE_OUT_I;
   wire [N_OUT-1:0] oe_n_d   = mode_hiz ? {N_OUT{1'b1}} :
                               (mode_bsr ? {N_OUT{1'b0}} : CORE_OE_N_I);

   // Sample/preload leaves the core path untouched
   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         PIN_O      <= '0;
         PIN_OE_N_O <= '1;
         CORE_IN_O  <= '0;
      end else begin
         PIN_O      <= pin_d;
         PIN_OE_N_O <= oe_n_d;
         CORE_IN_O  <= pin_in_s;
      end
   end

   // Checks
   logic [2:0] tms_run_q;

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         tms_run_q <= '0;
      end else if (tck_rise) begin
         if (!tms_s) begin
            tms_run_q <= '0;
         end else if (tms_run_q != 3'h7) begin
            tms_run_q <= tms_run_q + 3'h1;
         end
      end
   end

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RESET_I);

   tlr_five_a: assert property (
      (tms_run_q >= 3'(bst_pkg::TLR_CLKS)) |-> st_tlr)
      else $error("five high mode clocks did not reach reset state");

   trst_tlr_a: assert property (
      !trst_n_s |=> st_tlr ##0 ir_q == bst_pkg::IR_IDCODE)
      else $error("test reset did not restore reset state and idcode");

   sel_dr_a: assert property (
      (tck_rise && st_sel_dr_w && !tms_s && trst_n_s) |=> st_cap_dr && $stable(bsr_sr_q))
      else $error("select-dr did not go to capture-dr");

   cap_ir_a: assert property (
      (tck_rise && st_cap_ir && trst_n_s) |=> ir_sr_q == bst_pkg::IR_CAPTURE)
      else $error("capture-ir did not load fixed pattern");

   upd_ir_a: assert property (
      (tck_fall && st_upd_ir && trst_n_s) |=> ir_q == $past(ir_sr_q))
      else $error("update-ir did not latch instruction");

   pause_hold_a: assert property (
      (st_pau_dr_w && !tck_rise) ##1 st_pau_dr_w |-> $stable(bsr_sr_q) && $stable(id_sr_q))
      else $error("registers moved in pause-dr");

   id_cap_a: assert property (
      (tck_rise && st_cap_dr && sel_id) |=> id_sr_q == ID_CODE)
      else $error("idcode not captured");

   byp_path_a: assert property (
      (tck_rise && st_sh_dr && sel_byp) |=> byp_q == $past(tdi_s))
      else $error("bypass bit did not follow serial in");

   tdo_shift_a: assert property (
      (tck_fall && st_sh_ir) |=> !TEST_SERIAL_OUT_OE_N_O && TEST_SERIAL_OUT_O == $past(ir_sr_q[0]))
      else $error("serial out wrong in shift-ir");

   highz_pins_a: assert property (
      (ir_q == bst_pkg::IR_HIGHZ) |=> PIN_OE_N_O == {N_OUT{1'b1}})
      else $error("outputs not floated under highz");

   ext_drive_a: assert property (
      (bst_pkg::drive_bsr(ir_q) && $stable(bsr_upd_q)) |=> PIN_O == $past(upd_out))
      else $error("pins not driven from boundary latch");

   cap_bsr_a: assert property (
      (tck_rise && st_cap_dr && sel_bsr) |=> bsr_sr_q == $past({CORE_OUT_I, pin_in_s}))
      else $error("boundary cells did not capture pins and core outputs");

   bsr_shift_a: assert property (
      (tck_rise && st_sh_dr && sel_bsr) |=>
         bsr_sr_q == {$past(tdi_s), $past(bsr_sr_q[BSR_LEN-1:1])})
      else $error("boundary register did not shift one stage");

   upd_dr_a: assert property (
      (tck_fall && st_upd_dr && sel_bsr) |=> bsr_upd_q == $past(bsr_sr_q))
      else $error("update latch did not take the shift path");

   ir_hold_a: assert property (
      (st_sh_ir && trst_n_s) |=> $stable(ir_q))
      else $error("current instruction moved during shift-ir");

   sel_ir_tlr_a: assert property (
      (tck_rise && st_sel_ir && tms_s && trst_n_s) |=> st_tlr)
      else $error("select-ir with mode high did not return to reset state");

   idle_stay_a: assert property (
      (tck_rise && st_idle && !tms_s && trst_n_s) |=> st_idle)
      else $error("idle state left with mode select low");

   state_hold_a: assert property (
      (!tck_rise && trst_n_s) |=> $stable(state))
      else $error("controller moved without a test clock rise");

   tdo_float_a: assert property (
      (tck_fall && !st_sh_dr && !st_sh_ir) |=> TEST_SERIAL_OUT_OE_N_O)
      else $error("serial out driven outside shift states");

   tdo_quiet_a: assert property (
      !tck_fall |=> $stable(TEST_SERIAL_OUT_O) && $stable(TEST_SERIAL_OUT_OE_N_O))
      else $error("serial out changed without a test clock fall");

   core_pins_a: assert property (
      (!bst_pkg::drive_bsr(ir_q) && ir_q != bst_pkg::IR_HIGHZ) |=>
         PIN_O == $past(CORE_OUT_I) && PIN_OE_N_O == $past(CORE_OE_N_I))
      else $error("pins left the core path in normal mode");
endmodule

/* dv/bst_host_model.sv */
// Model of the external scan controller that drives the test pins
`timescale 1ns/100ps
module bst_host_model (
   input  wire logic mclk_i,
   input  wire logic tdo_i,
   input  wire logic tdo_oe_n_i,
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   output logic      trst_n_o
);
   initial begin
      tck_o    = 1'b0;
      tms_o    = 1'b1;
      tdi_o    = 1'b0;
      trst_n_o = 1'b1;
   end

   // One 65 ns test clock, nearest to 64 ns that keeps pin changes just after
   // a system clock edge; the clock rests low between calls
   task automatic step(input logic tms, input logic tdi, input logic use_d,
                       output logic tdo, output logic oe_n);
      @(posedge mclk_i);
      #1;
      tms_o = tms;
      // Unused data line toggles so a stale level never passes for data
      tdi_o = use_d ? tdi : ~tdi_o;
      #12 tck_o = 1'b1;
      // A 33 ns high phase keeps the fall off a system clock edge
      #33 tck_o = 1'b0;
      // Serial out settles within three system clocks of the fall
      #17;
      // A floating line shows the inverse so stale data never passes
      tdo  = tdo_oe_n_i ? ~tdo_i : tdo_i;
      oe_n = tdo_oe_n_i;
   endtask

   task automatic test_reset(input int n);
      @(posedge mclk_i);
      #1 trst_n_o = 1'b0;
      repeat (n) @(posedge mclk_i);
      #1 trst_n_o = 1'b1;
      // Synchroniser needs a few clocks before the next test clock
      repeat (6) @(posedge mclk_i);
   endtask
endmodule

/* dv/bst_tap_test.sv */
// Self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
module bst_tap_test;
   localparam int          N_IN    = 8;
   localparam int          N_OUT   = 8;
   localparam logic [31:0] ID_WORD = {bst_pkg::ID_VERSION, bst_pkg::ID_PART,
                                      bst_pkg::ID_MAKER, 1'b1};
   logic             mclk;
   logic             reset;
   logic             tck;
   logic             tms;
   logic             tdi;
   logic             trst_n;
   logic             tdo;
   logic             tdo_oe_n;
   logic [N_IN-1:0]  pin_in;
   logic [N_IN-1:0]  core_in;
   logic [N_OUT-1:0] core_out;
   logic [N_OUT-1:0] core_oe_n;
   logic [N_OUT-1:0] pin_out;
   logic [N_OUT-1:0] pin_oe_n;
   int               mismatches;
   int               n_compared;

   bst_tap #(.N_IN(N_IN), .N_OUT(N_OUT)) i_dut (
      .MCLK_I                 (mclk),
      .RESET_I                (reset),
      .TEST_CLOCK_IN_I        (tck),
      .TEST_MODE_SELECT_I     (tms),
      .TEST_SERIAL_IN_I       (tdi),
      .TEST_RESET_N_I         (trst_n),
      .PIN_IN_I               (pin_in),
      .CORE_OUT_I             (core_out),
      .CORE_OE_N_I            (core_oe_n),
      .CORE_IN_O              (core_in),
      .PIN_O                  (pin_out),
      .PIN_OE_N_O             (pin_oe_n),
      .TEST_SERIAL_OUT_O      (tdo),
      .TEST_SERIAL_OUT_OE_N_O (tdo_oe_n)
   );

   bst_host_model i_host (
      .mclk_i     (mclk),
      .tdo_i      (tdo),
      .tdo_oe_n_i (tdo_oe_n),
      .tck_o      (tck),
      .tms_o      (tms),
      .tdi_o      (tdi),
      .trst_n_o   (trst_n)
   );

   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;

   task automatic print_verdict();
      if (mismatches == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Mode select path, first step in bit 0
   task automatic move(input logic [7:0] path, input int n);
      logic b;
      logic oe;
      for (int i = 0; i < n; i++) begin
         i_host.step(path[i], 1'b0, 1'b0, b, oe);
      end
   endtask

   // Starts in a capture state, ends in Run-Test-Idle; brk detours via pause
   task automatic scan(input int n, input logic [31:0] din, input int brk,
                       output logic [31:0] dout);
      logic b;
      logic oe;
      dout = '0;
      i_host.step(1'b0, 1'b0, 1'b0, b, oe);
      dout[0] = b;
      check("serial enable in shift", 32'h0, oe);
      for (int i = 0; i < n; i++) begin
         i_host.step(i == n - 1 || i == brk, din[i], 1'b1, b, oe);
         if (i == brk && i < n - 1) begin
            check("serial enable in pause", 32'h1, oe);
            move(8'b0000_0100, 3);
            i_host.step(1'b0, 1'b0, 1'b0, b, oe);
         end
         if (i < n - 1) begin
            dout[i + 1] = b;
            check("serial enable in shift", 32'h0, oe);
         end
      end
      check("serial enable after shift", 32'h1, oe);
      move(8'b0000_0001, 2);
   endtask

   task automatic load_ir(input logic [2:0] code);
      logic [31:0] cap;
      move(8'b0000_0011, 3);
      scan(3, {29'h0, code}, -1, cap);
      check("instruction capture", 32'h1, cap);
   endtask

   task automatic read_id();
      logic [31:0] d;
      move(8'b0000_0001, 2);
      scan(32, 32'h0, -1, d);
      check("identification word", ID_WORD, d);
   endtask

   task automatic check_pins(input logic [N_OUT-1:0] v, input logic [N_OUT-1:0] oe);
      repeat (3) @(posedge mclk);
      check("pin values", v, pin_out);
      check("pin enables", oe, pin_oe_n);
      check("core inputs", pin_in, core_in);
   endtask

   task automatic t_reset_state();
      check_pins(core_out, core_oe_n);
      check("core inputs", pin_in, core_in);
      check("serial enable idle", 32'h1, tdo_oe_n);
      move(8'b0000_0000, 1);
      read_id();
   endtask

   task automatic t_sample_extest();
      logic [31:0] d;
      load_ir(bst_pkg::IR_SAMPLE);
      move(8'b0000_0001, 2);
      scan(16, 32'h0000_5AC3, -1, d);
      check("sampled cells", {16'h0, core_out, pin_in}, d);
      check_pins(core_out, core_oe_n);
      load_ir(bst_pkg::IR_EXTEST);
      check_pins(8'h5A, 8'h00);
      @(posedge mclk);
      #1 core_out = 8'hC3;
      pin_in = 8'h69;
      move(8'b0000_0001, 2);
      scan(16, 32'h0000_9600, 7, d);
      check("extest capture", {16'h0, core_out, pin_in}, d);
      check_pins(8'h96, 8'h00);
   endtask

   task automatic t_codes();
      logic [2:0]  codes [5] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
      logic [31:0] d;
      for (int k = 0; k < 5; k++) begin
         load_ir(codes[k]);
         move(8'b0000_0001, 2);
         scan(4, 32'h0000_000B, -1, d);
         check("bypass path", 32'h6, d);
         check_pins(codes[k] == 3'h3 ? 8'h96 : core_out,
                    codes[k] == 3'h3 ? 8'h00 : codes[k] == 3'h4 ? 8'hFF : core_oe_n);
      end
   endtask

   task automatic t_five_ones();
      load_ir(bst_pkg::IR_EXTEST);
      move(8'b0000_0011, 4);
      move(8'b0001_1111, 5);
      check_pins(core_out, core_oe_n);
      move(8'b0000_0000, 1);
      read_id();
   endtask

   task automatic t_test_reset();
      load_ir(bst_pkg::IR_EXTEST);
      check_pins(8'h96, 8'h00);
      move(8'b0000_0001, 3);
      i_host.test_reset(10);
      check_pins(core_out, core_oe_n);
      move(8'b0000_0000, 1);
      read_id();
   endtask

   initial begin
      mismatches = 0;
      n_compared = 0;
      reset      = 1'b1;
      pin_in     = 8'hA5;
      core_out   = 8'h3C;
      core_oe_n  = 8'hF0;
      repeat (20) @(posedge mclk);
      #1 reset = 1'b0;
      repeat (8) @(posedge mclk);
      t_reset_state();
      t_sample_extest();
      t_codes();
      t_five_ones();
      t_test_reset();
      print_verdict();
   end

   // Scenarios need well under 100 us; this cuts a hang short
   initial begin
      #250_000;
      mismatches++;
      print_verdict();
   end
endmodule
